// ==== design/cis_alu.sv ====
/*
  Single cycle two operand ALU with result write back and flag outputs.
  Assumes operands are read from the register file in the same cycle.
*/
`default_nettype none
module cis_alu (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire cis_pkg::cis_alu_op_e op_in,
  input wire logic [cis_pkg::DATA_W-1:0] a_in,
  input wire logic [cis_pkg::DATA_W-1:0] b_in,
  input wire logic [cis_pkg::WB_ADDR_W-1:0] dest_in,
  output logic [cis_pkg::DATA_W-1:0] result_out,
  output logic wb_we_out,
  output logic [cis_pkg::WB_ADDR_W-1:0] wb_addr_out,
  output logic flags_we_out,
  output logic [cis_pkg::ALU_FLAG_W-1:0] flags_out,
  output logic [cis_pkg::ALU_FLAG_W-1:0] flags_mask_out
);
  logic [cis_pkg::DATA_W:0] sum9;
  logic [cis_pkg::DATA_W:0] dif9;
  logic [cis_pkg::DATA_W-1:0] res_nxt;
  logic c_f, h_f, v_f, n_f;

  assign sum9 = {1'b0, a_in} + {1'b0, b_in};
  assign dif9 = {1'b0, a_in} - {1'b0, b_in};

  // Result and flags settle within the issuing cycle
  always_comb begin
    res_nxt = a_in;
    c_f = 1'b0;
    h_f = 1'b0;
    v_f = 1'b0;
    flags_mask_out = 6'h1E;
    unique case (op_in)
      cis_pkg::CIS_ADD: begin
        res_nxt = sum9[7:0];
        c_f = sum9[8];
        h_f = (a_in[3] & b_in[3]) | (b_in[3] & ~res_nxt[3])
            | (~res_nxt[3] & a_in[3]);
        v_f = (a_in[7] & b_in[7] & ~res_nxt[7])
            | (~a_in[7] & ~b_in[7] & res_nxt[7]);
        flags_mask_out = 6'h3F;
      end
      cis_pkg::CIS_SUB: begin
        res_nxt = dif9[7:0];
        c_f = dif9[8];
        h_f = (~a_in[3] & b_in[3]) | (b_in[3] & res_nxt[3])
            | (res_nxt[3] & ~a_in[3]);
        v_f = (a_in[7] & ~b_in[7] & ~res_nxt[7])
            | (~a_in[7] & b_in[7] & res_nxt[7]);
        flags_mask_out = 6'h3F;
      end
      cis_pkg::CIS_AND: res_nxt = a_in & b_in;
      cis_pkg::CIS_OR: res_nxt = a_in | b_in;
      cis_pkg::CIS_XOR: res_nxt = a_in ^ b_in;
      // A move leaves every flag alone
      cis_pkg::CIS_MOV: begin
        res_nxt = b_in;
        flags_mask_out = 6'h00;
      end
      default: res_nxt = a_in;
    endcase
  end

  assign n_f = res_nxt[7];
  assign flags_we_out = valid_in;
  assign flags_out = {h_f, n_f ^ v_f, v_f, n_f, ~|res_nxt, c_f};

  // Write back lands on the edge that closes the issuing cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= 8'h00;
      wb_we_out <= 1'b0;
      wb_addr_out <= 5'h00;
    end else begin
      result_out <= res_nxt;
      wb_we_out <= valid_in;
      wb_addr_out <= dest_in;
    end
  end

  a_alu_add_once: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      valid_in && op_in == cis_pkg::CIS_ADD |=> wb_we_out
      && result_out == $past(a_in) + $past(b_in))
    else $error("add result not written back after one cycle");
endmodule : cis_alu
`default_nettype wire

// ==== design/cis_arb_if.sv ====
/*
  Carrier between the sequencer and its priority arbiter.
  Assumes the arbiter is purely combinational.
*/
`default_nettype none
interface cis_arb_if;
  logic [cis_pkg::NUM_SRC-1:0] req;
  logic relocate;
  logic grant_valid;
  logic [cis_pkg::SRC_IDX_W-1:0] grant_idx;
  logic [cis_pkg::PC_W-1:0] grant_vec;
  modport arb (input req, relocate, output grant_valid, grant_idx, grant_vec);
  modport seq (output req, relocate, input grant_valid, grant_idx, grant_vec);
endinterface : cis_arb_if
`default_nettype wire

// ==== design/cis_arbiter.sv ====
/*
  Fixed priority arbiter and vector address generator.
  Assumes request bit 0 is the external request zero, the highest source.
*/
`default_nettype none
module cis_arbiter (
  cis_arb_if.arb arb_if
);
  // Lowest index wins, which is also the lowest vector address
  function automatic logic [cis_pkg::SRC_IDX_W-1:0] cis_first_set(
      input logic [cis_pkg::NUM_SRC-1:0] v);
    logic [cis_pkg::SRC_IDX_W-1:0] idx;
    idx = '0;
    for (int i = cis_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = i[cis_pkg::SRC_IDX_W-1:0];
      end
    end
    return idx;
  endfunction : cis_first_set

  logic [cis_pkg::SRC_IDX_W-1:0] idx;
  logic [cis_pkg::PC_W-1:0] slot;

  // Slot 0 belongs to reset, so source n sits in slot n + 1
  assign idx = cis_first_set(arb_if.req);
  assign slot = cis_pkg::PC_W'(idx) + cis_pkg::PC_W'(1);
  assign arb_if.grant_valid = |arb_if.req;
  assign arb_if.grant_idx = idx;
  assign arb_if.grant_vec = cis_pkg::cis_vec_base(arb_if.relocate)
      + cis_pkg::PC_W'(slot * cis_pkg::VEC_STRIDE);
endmodule : cis_arbiter
`default_nettype wire

// ==== design/cis_pkg.sv ====
/*
  Shared constants, types and helpers of the interrupt sequencer.
  Assumes a single core clock domain and 13-bit word program counters.
*/
`default_nettype none
package cis_pkg;
  localparam int NUM_SRC = 8;
  localparam int SRC_IDX_W = 3;
  localparam int PC_W = 13;
  localparam int SP_W = 16;
  localparam int DATA_W = 8;
  localparam int WB_ADDR_W = 5;
  // Status register layout
  localparam int GIE_BIT = 7;
  localparam int T_BIT = 6;
  localparam int H_BIT = 5;
  localparam int S_BIT = 4;
  localparam int V_BIT = 3;
  localparam int N_BIT = 2;
  localparam int Z_BIT = 1;
  localparam int C_BIT = 0;
  localparam int ALU_FLAG_W = 6;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  // Program memory layout
  localparam logic [PC_W-1:0] APP_START = 13'h0000;
  localparam logic [PC_W-1:0] BOOT_START = 13'h1C00;
  localparam logic [PC_W-1:0] VEC_STRIDE = 13'h0002;
  // Source kinds: one bit per source, set for flag type, clear for level
  localparam logic [NUM_SRC-1:0] FLAG_TYPE_MASK = 8'h3F;
  // Sequence lengths in core clock cycles
  localparam int ENTRY_CYCLES = 4;
  localparam int WAKE_CYCLES = 4;
  localparam int RETURN_FROM_IRQ_INSTR_CYCLES = 4;
  localparam logic [SP_W-1:0] SP_RET_STEP = 16'h0002;
  localparam logic [SP_W-1:0] SP_ONE = 16'h0001;

  // Gray codes along wake, entry and return paths
  typedef enum logic [3:0] {
    CIS_IDLE = 4'h0,
    CIS_W0 = 4'h1,
    CIS_W1 = 4'h3,
    CIS_W2 = 4'h2,
    CIS_W3 = 4'h6,
    CIS_E0 = 4'h7,
    CIS_E1 = 4'h5,
    CIS_E2 = 4'h4,
    CIS_E3 = 4'hC,
    CIS_R0 = 4'hD,
    CIS_R1 = 4'hF,
    CIS_R2 = 4'hE,
    CIS_R3 = 4'hA
  } cis_state_e;

  typedef enum logic [2:0] {
    CIS_ADD = 3'h0,
    CIS_SUB = 3'h1,
    CIS_AND = 3'h2,
    CIS_OR = 3'h3,
    CIS_XOR = 3'h4,
    CIS_MOV = 3'h5
  } cis_alu_op_e;

  // Base of a vector table, boot section when selected
  function automatic logic [PC_W-1:0] cis_vec_base(input logic boot_sel);
    return boot_sel ? BOOT_START : APP_START;
  endfunction : cis_vec_base
endpackage : cis_pkg
`default_nettype wire

// ==== design/cpu_interrupt_sequencer.sv ====
/*
  Interrupt and reset sequencer of an 8-bit core: flags, gating,
  priority dispatch, entry and return sequences, stack pointer and
  status register, plus the single cycle ALU.
  Assumes the pipeline pulses instr_done_in on the last cycle of every
  instruction, presents the return address on pc_in, and returns stack
  read data one cycle after stack_re_out.
*/
// Operation
// - Core runs straight on the input clock
// - Two register ALU operation completes in one cycle
// - Reset and each source own a vector
// - Take only when local and global enables set
// - Boot lock bits suppress interrupts by PC region
// - Lower vector wins; reset first, source zero next
// - Relocate select moves vectors to boot section
// - Boot fuse moves reset vector to boot section
// - Accepting an interrupt clears global enable
// - Global enable set in handler allows nesting
// - Hardware clears flag when vectoring to handler
// - Writing one clears flag, zero keeps it
// - Disabled flag stays latched until enabled or cleared
// - Flags kept while globally off, served by priority
// - Level request only while its condition holds
// - One instruction runs after return before service
// - Global disable blocks even simultaneous interrupts
// - Instruction after global enable runs before service
// - Entry takes four cycles pushing the PC
// - Multi-cycle instruction finishes before entry
// - Wake from sleep adds four entry cycles
// - Return takes four cycles, pops PC, sets enable
// - Global enable is status bit 7, reset zero
// - Entry push lowers stack pointer by two
`default_nettype none
module cpu_interrupt_sequencer (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [cis_pkg::NUM_SRC-1:0] src_req_in,
  input wire logic [cis_pkg::NUM_SRC-1:0] src_enable_in,
  input wire logic flag_clear_wr_in,
  input wire logic [cis_pkg::NUM_SRC-1:0] flag_clear_data_in,
  input wire logic vector_relocate_select_in,
  input wire logic reset_vector_boot_fuse_in,
  input wire logic boot_lock_app_bit_in,
  input wire logic boot_lock_boot_bit_in,
  input wire logic [cis_pkg::PC_W-1:0] pc_in,
  input wire logic instr_done_in,
  input wire logic instr_sei_in,
  input wire logic global_irq_disable_instr_in,
  input wire logic return_from_irq_instr_in,
  input wire logic sleep_in,
  input wire logic status_wr_in,
  input wire logic [cis_pkg::DATA_W-1:0] status_wr_data_in,
  input wire logic sp_wr_in,
  input wire logic [cis_pkg::SP_W-1:0] sp_wr_data_in,
  input wire logic [cis_pkg::DATA_W-1:0] stack_rdata_in,
  input wire logic alu_valid_in,
  input wire cis_pkg::cis_alu_op_e alu_op_in,
  input wire logic [cis_pkg::DATA_W-1:0] alu_a_in,
  input wire logic [cis_pkg::DATA_W-1:0] alu_b_in,
  input wire logic [cis_pkg::WB_ADDR_W-1:0] alu_dest_in,
  output logic pc_load_out,
  output logic [cis_pkg::PC_W-1:0] pc_load_addr_out,
  output logic stall_out,
  output logic stack_we_out,
  output logic stack_re_out,
  output logic [cis_pkg::SP_W-1:0] stack_addr_out,
  output logic [cis_pkg::DATA_W-1:0] stack_wdata_out,
  output logic [cis_pkg::SP_W-1:0] sp_out,
  output logic [cis_pkg::DATA_W-1:0] status_flags_reg_out,
  output logic [cis_pkg::NUM_SRC-1:0] flags_out,
  output logic irq_ack_out,
  output logic [cis_pkg::SRC_IDX_W-1:0] irq_ack_id_out,
  output logic wake_out,
  output logic [cis_pkg::DATA_W-1:0] alu_result_out,
  output logic alu_wb_we_out,
  output logic [cis_pkg::WB_ADDR_W-1:0] alu_wb_addr_out
);
  cis_pkg::cis_state_e state_r;
  logic [cis_pkg::DATA_W-1:0] status_flags_reg_r;
  logic [cis_pkg::DATA_W-1:0] status_flags_reg_nxt;
  logic [cis_pkg::SP_W-1:0] sp_r;
  logic [cis_pkg::NUM_SRC-1:0] flag_r;
  logic [cis_pkg::NUM_SRC-1:0] flag_set;
  logic [cis_pkg::NUM_SRC-1:0] flag_clr;
  logic [cis_pkg::NUM_SRC-1:0] pending;
  logic [cis_pkg::SRC_IDX_W-1:0] idx_r;
  logic [cis_pkg::PC_W-1:0] vec_r;
  logic [cis_pkg::PC_W-1:0] ret_pc_r;
  logic boot_done_r;
  logic inhibit_r;
  logic gie_eff;
  logic suppress;
  logic pc_in_boot;
  logic take;
  logic return_from_irq_instr_go;
  logic enter_e0;
  logic alu_flags_we;
  logic [cis_pkg::ALU_FLAG_W-1:0] alu_flags;
  logic [cis_pkg::ALU_FLAG_W-1:0] alu_flags_mask;

  cis_arb_if arb ();

  // Every process below runs on mclk_in itself, no divided clock
  cis_arbiter u_arbiter (
    .arb_if(arb.arb)
  );

  cis_alu u_alu (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .valid_in(alu_valid_in),
    .op_in(alu_op_in),
    .a_in(alu_a_in),
    .b_in(alu_b_in),
    .dest_in(alu_dest_in),
    .result_out(alu_result_out),
    .wb_we_out(alu_wb_we_out),
    .wb_addr_out(alu_wb_addr_out),
    .flags_we_out(alu_flags_we),
    .flags_out(alu_flags),
    .flags_mask_out(alu_flags_mask)
  );

  // Flag sources use the latch, level sources bypass it
  for (genvar i = 0; i < cis_pkg::NUM_SRC; i++) begin : g_pend
    if (cis_pkg::FLAG_TYPE_MASK[i]) begin : g_flag
      assign pending[i] = flag_r[i];
    end else begin : g_level
      assign pending[i] = src_req_in[i];
    end
  end

  assign arb.req = pending & src_enable_in;
  assign arb.relocate = vector_relocate_select_in;

  // Lock bits forbid vectoring into the other section's table
  assign pc_in_boot = pc_in >= cis_pkg::BOOT_START;
  assign suppress = (boot_lock_app_bit_in & ~pc_in_boot
      & vector_relocate_select_in)
      | (boot_lock_boot_bit_in & pc_in_boot & ~vector_relocate_select_in);

  // A disable in this very cycle already masks the request
  assign gie_eff = status_flags_reg_r[cis_pkg::GIE_BIT]
      & ~global_irq_disable_instr_in;

  // Entry starts only at an instruction boundary, or from sleep
  assign take = state_r == cis_pkg::CIS_IDLE && boot_done_r
      && arb.grant_valid && gie_eff && !inhibit_r
      && !suppress && !return_from_irq_instr_in
      && (instr_done_in || sleep_in);
  assign return_from_irq_instr_go = state_r == cis_pkg::CIS_IDLE && boot_done_r
      && return_from_irq_instr_in;
  assign enter_e0 = (take && !sleep_in) || state_r == cis_pkg::CIS_W3;

  // Sequence state: wake padding, entry push, return pop
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= cis_pkg::CIS_IDLE;
    end else begin
      unique case (state_r)
        cis_pkg::CIS_IDLE: begin
          if (return_from_irq_instr_go) begin
            state_r <= cis_pkg::CIS_R0;
          end else if (take && sleep_in) begin
            state_r <= cis_pkg::CIS_W0;
          end else if (take) begin
            state_r <= cis_pkg::CIS_E0;
          end
        end
        cis_pkg::CIS_W0: state_r <= cis_pkg::CIS_W1;
        cis_pkg::CIS_W1: state_r <= cis_pkg::CIS_W2;
        cis_pkg::CIS_W2: state_r <= cis_pkg::CIS_W3;
        cis_pkg::CIS_W3: state_r <= cis_pkg::CIS_E0;
        cis_pkg::CIS_E0: state_r <= cis_pkg::CIS_E1;
        cis_pkg::CIS_E1: state_r <= cis_pkg::CIS_E2;
        cis_pkg::CIS_E2: state_r <= cis_pkg::CIS_E3;
        cis_pkg::CIS_E3: state_r <= cis_pkg::CIS_IDLE;
        cis_pkg::CIS_R0: state_r <= cis_pkg::CIS_R1;
        cis_pkg::CIS_R1: state_r <= cis_pkg::CIS_R2;
        cis_pkg::CIS_R2: state_r <= cis_pkg::CIS_R3;
        cis_pkg::CIS_R3: state_r <= cis_pkg::CIS_IDLE;
        default: state_r <= cis_pkg::CIS_IDLE;
      endcase
    end
  end

  // Winner, its vector and the return address are frozen on accept
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_r <= 3'h0;
      vec_r <= 13'h0000;
      ret_pc_r <= 13'h0000;
    end else if (take) begin
      idx_r <= arb.grant_idx;
      vec_r <= arb.grant_vec;
      ret_pc_r <= pc_in;
    end else if (state_r == cis_pkg::CIS_R1) begin
      ret_pc_r[12:8] <= stack_rdata_in[4:0];
    end else if (state_r == cis_pkg::CIS_R2) begin
      ret_pc_r[7:0] <= stack_rdata_in;
    end
  end

  // Reset vector is fetched once, on the first edge after release
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      boot_done_r <= 1'b0;
    end else begin
      boot_done_r <= 1'b1;
    end
  end

  // Program counter loads: reset vector, handler vector, return
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_load_out <= 1'b0;
      pc_load_addr_out <= 13'h0000;
    end else if (!boot_done_r) begin
      pc_load_out <= 1'b1;
      pc_load_addr_out <=
          cis_pkg::cis_vec_base(reset_vector_boot_fuse_in);
    end else if (state_r == cis_pkg::CIS_E3) begin
      pc_load_out <= 1'b1;
      pc_load_addr_out <= vec_r;
    end else if (state_r == cis_pkg::CIS_R3) begin
      pc_load_out <= 1'b1;
      pc_load_addr_out <= ret_pc_r;
    end else begin
      pc_load_out <= 1'b0;
    end
  end

  // Pipeline holds while any sequence owns the stack
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stall_out <= 1'b0;
    end else if (take || return_from_irq_instr_go) begin
      stall_out <= 1'b1;
    end else if (state_r == cis_pkg::CIS_E3
        || state_r == cis_pkg::CIS_R3) begin
      stall_out <= 1'b0;
    end
  end

  // Only the PC is stacked; status is left to the handler
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stack_we_out <= 1'b0;
      stack_re_out <= 1'b0;
      stack_addr_out <= 16'h0000;
      stack_wdata_out <= 8'h00;
    end else if (enter_e0) begin
      stack_we_out <= 1'b1;
      stack_addr_out <= sp_r;
      stack_wdata_out <= ret_pc_r[7:0];
      if (take) begin
        stack_wdata_out <= pc_in[7:0];
      end
    end else if (state_r == cis_pkg::CIS_E0) begin
      stack_addr_out <= sp_r - cis_pkg::SP_ONE;
      stack_wdata_out <= {3'h0, ret_pc_r[12:8]};
    end else if (return_from_irq_instr_go) begin
      stack_re_out <= 1'b1;
      stack_addr_out <= sp_r + cis_pkg::SP_ONE;
    end else if (state_r == cis_pkg::CIS_R0) begin
      stack_addr_out <= sp_r + cis_pkg::SP_RET_STEP;
    end else begin
      stack_we_out <= 1'b0;
      stack_re_out <= 1'b0;
    end
  end

  // Stack grows downward: minus two on entry, plus two on return
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sp_r <= 16'h0000;
    end else if (state_r == cis_pkg::CIS_E0) begin
      sp_r <= sp_r - cis_pkg::SP_RET_STEP;
    end else if (state_r == cis_pkg::CIS_R3) begin
      sp_r <= sp_r + cis_pkg::SP_RET_STEP;
    end else if (sp_wr_in) begin
      sp_r <= sp_wr_data_in;
    end
  end

  assign sp_out = sp_r;

  // Later lines win: accept clearing enable beats everything
  always_comb begin
    status_flags_reg_nxt = status_flags_reg_r;
    if (alu_flags_we) begin
      status_flags_reg_nxt[5:0] = (status_flags_reg_r[5:0]
          & ~alu_flags_mask) | (alu_flags & alu_flags_mask);
    end
    if (status_wr_in) begin
      status_flags_reg_nxt = status_wr_data_in;
    end
    if (instr_sei_in) begin
      status_flags_reg_nxt[cis_pkg::GIE_BIT] = 1'b1;
    end
    if (global_irq_disable_instr_in) begin
      status_flags_reg_nxt[cis_pkg::GIE_BIT] = 1'b0;
    end
    if (state_r == cis_pkg::CIS_R3) begin
      status_flags_reg_nxt[cis_pkg::GIE_BIT] = 1'b1;
    end
    if (take) begin
      status_flags_reg_nxt[cis_pkg::GIE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status_flags_reg_r <= cis_pkg::STATUS_RST;
    end else begin
      status_flags_reg_r <= status_flags_reg_nxt;
    end
  end

  assign status_flags_reg_out = status_flags_reg_r;

  // Guard of one instruction after a return or a fresh enable
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      inhibit_r <= 1'b0;
    end else if (state_r == cis_pkg::CIS_R3) begin
      inhibit_r <= 1'b1;
    end else if (instr_sei_in
        && !status_flags_reg_r[cis_pkg::GIE_BIT]) begin
      inhibit_r <= 1'b1;
    end else if (instr_done_in) begin
      inhibit_r <= 1'b0;
    end
  end

  // New events win over both kinds of clear in the same cycle
  assign flag_set = src_req_in & cis_pkg::FLAG_TYPE_MASK;
  assign flag_clr = (flag_clear_wr_in ? flag_clear_data_in : 8'h00)
      | (state_r == cis_pkg::CIS_E3 ?
         (cis_pkg::FLAG_TYPE_MASK & (8'h01 << idx_r)) : 8'h00);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_r <= 8'h00;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | flag_set;
    end
  end

  assign flags_out = flag_r;

  // Accept pulse, winner id and wake indication
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ack_out <= 1'b0;
      irq_ack_id_out <= 3'h0;
      wake_out <= 1'b0;
    end else begin
      irq_ack_out <= take;
      wake_out <= take && sleep_in;
      if (take) begin
        irq_ack_id_out <= arb.grant_idx;
      end
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  a_cli_blocks_take: assert property (
      global_irq_disable_instr_in |=> !irq_ack_out)
    else $error("interrupt taken beside a global disable");
  a_accept_clears_gie: assert property (
      irq_ack_out |-> !status_flags_reg_r[cis_pkg::GIE_BIT])
    else $error("global enable still set after accept");
  a_accept_needs_gie: assert property (
      irq_ack_out |-> $past(status_flags_reg_r[cis_pkg::GIE_BIT]))
    else $error("interrupt accepted with global enable clear");
  a_entry_four_cycles: assert property (
      irq_ack_out && !wake_out |-> (!pc_load_out)[*4] ##1 pc_load_out)
    else $error("entry did not load the vector after four cycles");
  a_wake_eight_cycles: assert property (
      wake_out |-> ##8 (pc_load_out && pc_load_addr_out == $past(vec_r)))
    else $error("wake entry did not take eight cycles");
  a_push_sp_two: assert property (
      irq_ack_out && !wake_out && !sp_wr_in
      |=> sp_out == $past(sp_out) - cis_pkg::SP_RET_STEP)
    else $error("entry push did not lower sp by two");
  a_return_from_irq_instr_return: assert property (
      return_from_irq_instr_go |-> ##5 (pc_load_out && status_flags_reg_r[cis_pkg::GIE_BIT]
      && sp_out == $past(sp_out, 5) + cis_pkg::SP_RET_STEP))
    else $error("return sequence wrong after four cycles");
  a_after_return_from_irq_instr_one: assert property (
      inhibit_r |=> !irq_ack_out)
    else $error("interrupt served before one instruction ran");
  a_sei_defers_take: assert property (
      instr_sei_in && !status_flags_reg_r[cis_pkg::GIE_BIT]
      |=> (!irq_ack_out)[*2])
    else $error("interrupt served right after global enable");
  a_prio_lowest_wins: assert property (
      arb.grant_valid |-> arb.req[arb.grant_idx] && (arb.req
      & ((8'h01 << arb.grant_idx) - 8'h01)) == 8'h00)
    else $error("grant is not the lowest pending source");
  a_w1c_clears: assert property (
      flag_clear_wr_in |=> (flags_out & $past(flag_clear_data_in)
      & ~$past(src_req_in)) == 8'h00)
    else $error("write one did not clear the flag");
endmodule : cpu_interrupt_sequencer
`default_nettype wire

// ==== test/cis_stack_model.sv ====
/* Behavioural data stack memory beside the sequencer.
   Assumes one clock; read data follows a read strobe by one cycle. */
`default_nettype none
module cis_stack_model (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic re_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // Outside a read the bus shows the inverse, so a stale byte never passes
  always @(posedge clk_in) begin
    if (we_in)
      mem[addr_in[7:0]] <= wdata_in;
    rdata_out <= re_in ? mem[addr_in[7:0]] : ~rdata_out;
  end
endmodule : cis_stack_model
`default_nettype wire

// ==== test/testbench.sv ====
/* Self-checking bench: random flags, gating, entry, return, clears.
   Assumes the stack model answers the sequencer's stack port. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, rst_in, flag_clear_wr_in, vector_relocate_select_in;
  logic reset_vector_boot_fuse_in, instr_done_in, instr_sei_in, sleep_in;
  logic global_irq_disable_instr_in, return_from_irq_instr_in, sp_wr_in;
  logic boot_lock_app_bit_in, boot_lock_boot_bit_in, status_wr_in;
  logic pc_load_out, stack_we_out, stack_re_out, irq_ack_out;
  logic [7:0] src_req_in, src_enable_in, flag_clear_data_in, flags_out;
  logic [7:0] stack_rdata_in, stack_wdata_out, status_flags_reg_out;
  logic [7:0] status_wr_data_in, c, rem;
  logic [12:0] pc_in, pc_load_addr_out;
  logic [15:0] sp_wr_data_in, stack_addr_out, sp_out;
  logic [2:0] irq_ack_id_out;
  logic [6:0] st;
  logic [5:0] m;
  int seed, err_total, num_checks, cyc, n, w;
  // Strobes: sp write, flag clear, status write, set, clear, done, return
  assign {sp_wr_in, flag_clear_wr_in, status_wr_in, instr_sei_in,
          global_irq_disable_instr_in, instr_done_in,
          return_from_irq_instr_in} = st;
  cpu_interrupt_sequencer u_dut (
    .mclk_in, .rst_in, .src_req_in, .src_enable_in, .flag_clear_wr_in,
    .flag_clear_data_in, .vector_relocate_select_in,
    .reset_vector_boot_fuse_in, .boot_lock_app_bit_in,
    .boot_lock_boot_bit_in, .pc_in, .instr_done_in, .instr_sei_in,
    .global_irq_disable_instr_in, .return_from_irq_instr_in, .sleep_in,
    .status_wr_in, .status_wr_data_in, .sp_wr_in, .sp_wr_data_in,
    .stack_rdata_in, .alu_valid_in(flag_clear_wr_in),
    .alu_op_in(cis_pkg::CIS_ADD), .alu_a_in(c), .alu_b_in(rem),
    .alu_dest_in(5'h00), .pc_load_out,
    .pc_load_addr_out, .stall_out(), .stack_we_out, .stack_re_out,
    .stack_addr_out, .stack_wdata_out, .sp_out, .status_flags_reg_out,
    .flags_out, .irq_ack_out, .irq_ack_id_out, .wake_out(),
    .alu_result_out(), .alu_wb_we_out(), .alu_wb_addr_out()
  );
  cis_stack_model u_stack (.clk_in(mclk_in), .we_in(stack_we_out),
    .re_in(stack_re_out), .addr_in(stack_addr_out),
    .wdata_in(stack_wdata_out), .rdata_out(stack_rdata_in));
  // Core clock, 4 ns period
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // Hang guard: the whole run needs well under 1000 cycles
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Strobes rise at a falling edge and drop at the next rising edge, so exactly one rising edge sees them
  task automatic pls(input logic [6:0] v);
    st = v;
    @(posedge mclk_in);
    st <= 7'h00;
    @(negedge mclk_in);
  endtask : pls
  task automatic wt;
    n = 0;
    while (pc_load_out !== 1'b1 && n < 20) begin
      @(negedge mclk_in);
      n++;
    end
  endtask : wt
  function automatic logic [15:0] vec(input logic r, input int i);
    return (r ? 16'h1C00 : 16'h0000) + 16'(2 * (i + 1));
  endfunction : vec
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // Two reset passes, one per reset vector fuse setting
  initial begin
    seed = 83153;
    st = 7'h00;
    {src_req_in, src_enable_in, status_wr_data_in} = 24'h00_0000;
    {sleep_in, boot_lock_app_bit_in, boot_lock_boot_bit_in} = 3'h0;
    {vector_relocate_select_in, pc_in, sp_wr_data_in} = 30'h0000_0400;
    for (int f = 0; f < 2; f++) begin
      rst_in = 1'b1;
      reset_vector_boot_fuse_in = f[0];
      repeat (16) @(negedge mclk_in);
      chk("status_rst", 16'h0000, {8'h00, status_flags_reg_out});
      rst_in = 1'b0;
      @(negedge mclk_in);
      chk("rst_vec", vec(f[0], -1) | 16'h8000,
          {pc_load_out, 2'b00, pc_load_addr_out});
      pls(7'h40);
      repeat (5) begin
        m = 6'($random(seed));
        if (m == 6'h00)
          m = 6'h20;
        w = 0;
        for (int i = 5; i >= 0; i--)
          if (m[i])
            w = i;
        rem = {2'b00, m} & ~(8'h01 << w);
        vector_relocate_select_in = 1'($random(seed));
        pc_in = 13'($random(seed));
        sleep_in = m[1];
        src_enable_in = 8'h00;
        src_req_in = {2'b10, m};
        @(negedge mclk_in);
        src_req_in = 8'h00;
        chk("flags_set", {10'h000, m}, {8'h00, flags_out});
        pls(7'h08);
        pls(7'h02);
        chk("sei_next", 16'h0000, {15'h0000, irq_ack_out});
        pls(7'h02);
        chk("src_off", 16'h0000, {15'h0000, irq_ack_out});
        src_enable_in = 8'hFF;
        pls(7'h06);
        chk("cli_same", 16'h0000,
            {14'h0000, irq_ack_out, status_flags_reg_out[7]});
        pls(7'h08);
        pls(7'h02);
        chk("sei_next", 16'h0000, {15'h0000, irq_ack_out});
        pls(7'h02);
        chk("ack", {13'h0001, 3'(w)}, {12'h000, irq_ack_out,
            irq_ack_id_out});
        chk("gie_off", 16'h0000, {15'h0000, status_flags_reg_out[7]});
        wt();
        chk("entry_len", 16'(sleep_in ? 8 : 4), 16'(n));
        sleep_in = 1'b0;
        chk("vector", vec(vector_relocate_select_in, w),
            {3'b000, pc_load_addr_out});
        chk("sp_push", 16'h03FE, sp_out);
        chk("flag_hw", {8'h00, rem}, {8'h00, flags_out});
        pls(7'h01);
        wt();
        chk("ret_len", 16'h0004, 16'(n));
        chk("ret_pc", {3'b000, pc_in}, {3'b000, pc_load_addr_out});
        chk("ret_sp", 16'h8400,
            {status_flags_reg_out[7], sp_out[14:0]});
        pls(7'h02);
        chk("after_ret", 16'h0000, {15'h0000, irq_ack_out});
        {boot_lock_app_bit_in, vector_relocate_select_in, pc_in} = 15'h6000;
        pls(7'h02);
        chk("lock_off", 16'h0000, {15'h0000, irq_ack_out});
        boot_lock_app_bit_in = 1'b0;
        c = 8'($random(seed));
        flag_clear_data_in = c;
        pls(7'h20);
        chk("flag_w1c", {8'h00, rem & ~c}, {8'h00, flags_out});
        flag_clear_data_in = 8'hFF;
        pls(7'h30);
      end
    end
    results();
  end
endmodule : testbench
`default_nettype wire
